// [shared/sdb_pkg.sv]
// constants, encodings and carrier types for the device-side burst access block
// assumes one 200 MHz clock; every pin arrives from outside that clock's domain
package sdb_pkg;

	// array shape: eight banks, x16 pins, 8n prefetch
	localparam int BANK_W    = 3;
	localparam int ADDR_W    = 13;
	localparam int LANES     = 2;
	localparam int LANE_W    = 8;
	localparam int BEAT_W    = LANES * LANE_W;
	localparam int BEATS     = 8;
	localparam int SLOTS     = 16;
	localparam int AP_BIT    = 10;
	localparam int CHOP_BIT  = 12;
	localparam int FIFO_DEPTH = 16;

	// burst lengths in beats
	localparam logic [3:0] BL8_BEATS = 4'h8;
	localparam logic [3:0] BC4_BEATS = 4'h4;

	// internal self-initialisation time after the reset pin releases
	localparam int CLK_MHZ     = 200;
	localparam int INIT_US     = 500;
	localparam int INIT_CYCLES = INIT_US * CLK_MHZ;
	localparam int INIT_CNT_W  = 17;

	// {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_WR  = 3'h4;
	localparam logic [2:0] CMD_PRE = 3'h2;

	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_INIT  = 2'h1,
		ST_READY = 2'h3
	} sdb_state_type;

	// command, address and control pins
	typedef struct packed {
		logic                reset_n;
		logic                cke;
		logic                cs_n;
		logic                ras_n;
		logic                cas_n;
		logic                we_n;
		logic                termination_control;
		logic [BANK_W-1:0]   bank_select;
		logic [ADDR_W-1:0]   row_col_lines;
	} sdb_cmd_pins_type;

	// data pins: lane 0 is lower_byte_lane, lane 1 upper_byte_lane;
	// strobe pair bit 1 is the true strobe, bit 0 the complement
	typedef struct packed {
		logic [LANES-1:0][LANE_W-1:0] byte_lane;
		logic [LANES-1:0][1:0]        strobe_pair;
	} sdb_data_pins_type;

endpackage

// [design/sdb_fifo.sv]
// small first-in first-out buffer with a registered output stage
// assumes the producer and consumer share clk; rst is synchronous, active high
module sdb_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [PW:0]                 cnt;
		logic                        ov;
		logic [WIDTH-1:0]            od;
	} sdb_fifo_state_type;

	sdb_fifo_state_type q;
	sdb_fifo_state_type d;
	logic               push;
	logic               pop;

	// full is honest: the output register does not count as free space
	assign in_ready  = (q.cnt != DEPTH[PW:0]);
	assign out_valid = q.ov;
	assign out_data  = q.od;
	assign push      = in_valid && in_ready;
	assign pop       = (q.cnt != '0) && (!q.ov || out_ready);

	// pointer and output stage update
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'b1;
		end
		if (out_ready)
			d.ov = 1'b0;
		if (pop) begin
			d.od = q.mem[q.rp];
			d.ov = 1'b1;
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			q.mem <= '0;
			q.wp  <= '0;
			q.rp  <= '0;
			q.cnt <= '0;
			q.ov  <= 1'b0;
			q.od  <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// [design/sdb_core.sv]
// device-side logic of an eight-bank burst memory: self-initialisation after the
// reset pin, activate/read/write/precharge decode, 8n prefetch word per access,
// eight or four beat bursts, differential strobes per byte lane
// assumes every pin is asynchronous to clk and passes two flip-flops first;
// one beat per clk stands in for each half-clock transfer at the pins
// Operation
// - each lane strobe pair goes with its byte: device on reads, controller on writes
// - read strobe edges align with data; write data sampled at controller strobe edges
// - strobes only used as a true/complement pair; no single-ended mode
// - array holds eight banks picked by the three bank select lines
// - one access moves one 8n core word as eight n-bit beats at pins
// - bursts start at selected column, eight beats or four when chopped
// - activate first; bank and row latched from lines registered with it
// - read/write carry start column, auto-close bit and chop select bit
// - device initialises itself after reset with no need for external clock; here the wait counts INIT_WAIT clk cycles
// - input-only command, address and control pins carry no termination
// - auto-close bit high closes the accessed bank after the burst
// - chop select bit high gives full burst, low gives chopped burst
module sdb_core #(
	parameter int INIT_WAIT = sdb_pkg::INIT_CYCLES
) (
	// clock and reset
	clk,
	rst,
	// burst mode straps, same clock domain
	otf_chop_en,
	fixed_chop,
	burst_interleave,
	// command and address pins
	cmd_pins,
	// data pins split into input, output and enables
	data_pins_i,
	data_pins_o,
	data_oe,
	strobe_oe,
	// status
	init_done,
	termination_on
);
	import sdb_pkg::*;

	input  wire logic                       clk;
	input  wire logic                       rst;
	input  wire logic                       otf_chop_en;
	input  wire logic                       fixed_chop;
	input  wire logic                       burst_interleave;
	input  wire sdb_pkg::sdb_cmd_pins_type  cmd_pins;
	input  wire sdb_pkg::sdb_data_pins_type data_pins_i;
	output sdb_pkg::sdb_data_pins_type      data_pins_o;
	output logic [sdb_pkg::LANES-1:0]       data_oe;
	output logic [sdb_pkg::LANES-1:0]       strobe_oe;
	output logic                            init_done;
	output logic                            termination_on;

	typedef logic [BEATS-1:0][LANES-1:0][LANE_W-1:0] sdb_word_type;

	typedef struct packed {
		sdb_cmd_pins_type                 c1;
		sdb_cmd_pins_type                 c2;
		sdb_data_pins_type                p1;
		sdb_data_pins_type                p2;
		logic [LANES-1:0]                 stb_prev;
		sdb_state_type                    st;
		logic [INIT_CNT_W-1:0]            init_cnt;
		logic [BEATS-1:0]                 active;
		logic [BEATS-1:0]                 row_lsb;
		logic [SLOTS-1:0][BEATS-1:0][BEAT_W-1:0] array;
		sdb_word_type                     rd_word;
		logic [3:0]                       rd_left;
		logic [2:0]                       rd_i;
		logic [2:0]                       rd_col;
		logic [BANK_W-1:0]                rd_bank;
		logic                             rd_ap;
		logic [LANES-1:0][3:0]            wr_left;
		logic [LANES-1:0][2:0]            wr_i;
		logic [2:0]                       wr_col;
		logic [3:0]                       wr_slot;
		logic [BANK_W-1:0]                wr_bank;
		logic                             wr_ap;
		sdb_data_pins_type                out;
		logic                             oe;
		logic                             init_done;
		logic                             term;
	} sdb_core_state_type;

	sdb_core_state_type q;
	sdb_core_state_type d;
	logic               f_in_valid;
	logic               f_in_ready;
	logic [BEAT_W-1:0]  f_in_data;
	logic               f_out_valid;
	logic               f_out_ready;
	logic [BEAT_W-1:0]  f_out_data;

	// burst order: interleaved xors the start, sequential wraps within nibble
	function automatic logic [2:0] beat_pos(input logic [2:0] col, input logic [2:0] i,
	                                         input logic inter);
		if (inter)
			beat_pos = col ^ i;
		else
			beat_pos = {col[2] ^ i[2], col[1:0] + i[1:0]};
	endfunction

	// read beats wait in the fifo; a low clock enable stalls the pins
	assign f_in_valid  = (q.rd_left != 4'h0);
	assign f_in_data   = q.rd_word[beat_pos(q.rd_col, q.rd_i, burst_interleave)];
	assign f_out_ready = q.c2.cke;

	sdb_fifo #(
		.WIDTH (BEAT_W),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (f_in_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// outputs straight from the state register
	assign data_pins_o    = q.out;
	assign data_oe        = {LANES{q.oe}};
	assign strobe_oe      = {LANES{q.oe}};
	assign init_done      = q.init_done;
	assign termination_on = q.term;

	// next-state logic
	always_comb begin
		logic       cmd_ok;
		logic [2:0] cmd;
		logic [3:0] len;
		logic       edge_ok;
		logic [2:0] pos;
		cmd_ok  = 1'b0;
		cmd     = 3'h0;
		len     = 4'h0;
		edge_ok = 1'b0;
		pos     = 3'h0;
		d       = q;

		// two-flop synchronisers; first stage only feeds the second
		d.c1 = cmd_pins;
		d.c2 = q.c1;
		d.p1 = data_pins_i;
		d.p2 = q.p1;
		for (int l = 0; l < LANES; l++)
			d.stb_prev[l] = q.p2.strobe_pair[l][1];

		cmd    = {q.c2.ras_n, q.c2.cas_n, q.c2.we_n};
		cmd_ok = (q.st == ST_READY) && q.c2.cke && !q.c2.cs_n;
		// chop bit high means full burst
		if (otf_chop_en)
			len = q.c2.row_col_lines[CHOP_BIT] ? BL8_BEATS : BC4_BEATS;
		else
			len = fixed_chop ? BC4_BEATS : BL8_BEATS;

		case (q.st)
			ST_RESET: begin
				if (q.c2.reset_n)
					d.st = ST_INIT;
			end
			ST_INIT: begin
				d.init_cnt = q.init_cnt + 1'b1;
				if (q.init_cnt == INIT_CNT_W'(INIT_WAIT - 1)) begin
					d.st        = ST_READY;
					d.init_done = 1'b1;
				end
			end
			ST_READY: begin
				if (cmd_ok && cmd == CMD_ACT) begin
					// latch bank and row at activate
					d.active[q.c2.bank_select]  = 1'b1;
					d.row_lsb[q.c2.bank_select] = q.c2.row_col_lines[0];
				end
				if (cmd_ok && cmd == CMD_PRE) begin
					if (q.c2.row_col_lines[AP_BIT])
						d.active = '0;
					else
						d.active[q.c2.bank_select] = 1'b0;
				end
				// read takes start column, auto-close and chop select
				if (cmd_ok && cmd == CMD_RD && q.active[q.c2.bank_select] && q.rd_left == 4'h0) begin
					// whole 8n word fetched from the core at once
					d.rd_word = q.array[{q.c2.bank_select, q.row_lsb[q.c2.bank_select]}];
					d.rd_left = len;
					d.rd_i    = 3'h0;
					d.rd_col  = q.c2.row_col_lines[2:0];
					d.rd_bank = q.c2.bank_select;
					d.rd_ap   = q.c2.row_col_lines[AP_BIT];
				end
				// write takes start column, auto-close and chop select
				if (cmd_ok && cmd == CMD_WR && q.active[q.c2.bank_select] && q.wr_left == '0) begin
					d.wr_left = {LANES{len}};
					d.wr_i    = '0;
					d.wr_col  = q.c2.row_col_lines[2:0];
					d.wr_slot = {q.c2.bank_select, q.row_lsb[q.c2.bank_select]};
					d.wr_bank = q.c2.bank_select;
					d.wr_ap   = q.c2.row_col_lines[AP_BIT];
				end
			end
			default: d.st = ST_RESET;
		endcase

		// read beats leave in burst order from the start column
		if (f_in_valid && f_in_ready) begin
			d.rd_i    = q.rd_i + 1'b1;
			d.rd_left = q.rd_left - 1'b1;
			// close the bank once the last beat enters the fifo
			if (q.rd_left == 4'h1 && q.rd_ap)
				d.active[q.rd_bank] = 1'b0;
		end

		// write beats, each lane on its own strobe edge
		for (int l = 0; l < LANES; l++) begin
			// an edge counts only while the pair is complementary
			edge_ok = (q.p2.strobe_pair[l][1] != q.stb_prev[l]) &&
			          (q.p2.strobe_pair[l][1] != q.p2.strobe_pair[l][0]);
			if (edge_ok && q.wr_left[l] != 4'h0) begin
				// data sampled at the controller's strobe edge
				pos = beat_pos(q.wr_col, q.wr_i[l], burst_interleave);
				d.array[q.wr_slot][pos][l*LANE_W +: LANE_W] = q.p2.byte_lane[l];
				d.wr_i[l]    = q.wr_i[l] + 1'b1;
				d.wr_left[l] = q.wr_left[l] - 1'b1;
			end
		end
		// write closes its bank once both lanes finish
		if (q.wr_left != '0 && d.wr_left == '0 && q.wr_ap)
			d.active[q.wr_bank] = 1'b0;

		// device drives both strobe pairs and lanes on read beats
		d.oe = f_out_valid && f_out_ready;
		if (f_out_valid && f_out_ready) begin
			for (int l = 0; l < LANES; l++) begin
				d.out.byte_lane[l] = f_out_data[l*LANE_W +: LANE_W];
				// strobe flips in the same register as the data
				d.out.strobe_pair[l] = {~q.out.strobe_pair[l][1], q.out.strobe_pair[l][1]};
			end
		end

		// only data pins terminate; command inputs never do
		d.term = (q.st == ST_READY) && q.c2.termination_control;

		// reset pin low: closes banks and clears burst counts, array contents kept; back to waiting for release
		if (!q.c2.reset_n) begin
			d.st        = ST_RESET;
			d.init_cnt  = '0;
			d.init_done = 1'b0;
			d.active    = '0;
			d.rd_left   = 4'h0;
			d.wr_left   = '0;
			d.term      = 1'b0;
		end
	end

	// state register; pin stages reset to idle levels, reset pin treated as asserted
	always_ff @(posedge clk) begin
		if (rst) begin
			q          <= '0;
			q.c1.cs_n  <= 1'b1;
			q.c2.cs_n  <= 1'b1;
			q.out.strobe_pair <= {LANES{2'h1}};
			q.st       <= ST_RESET;
		end else begin
			q <= d;
		end
	end

endmodule

// [verification/sdb_ctrl_model.sv]
// controller-side model: command, address and write data pins of the device
// assumes its tasks are called at the falling clock edge by the bench
module sdb_ctrl_model (
	// clock
	input  wire logic                       clk,
	// pins toward the device
	output sdb_pkg::sdb_cmd_pins_type       cmd_pins,
	output sdb_pkg::sdb_data_pins_type      data_pins_i,
	// device drive, to resolve the shared wires
	input  wire sdb_pkg::sdb_data_pins_type data_pins_o,
	input  wire logic [1:0]                 data_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	import sdb_pkg::*;
	sdb_data_pins_type drv;

	// wire level: the device wins on a lane it drives
	always_comb begin
		data_pins_i = drv;
		for (int l = 0; l < LANES; l++) begin
			if (data_oe[l]) begin
				data_pins_i.byte_lane[l] = data_pins_o.byte_lane[l];
				data_pins_i.strobe_pair[l] = data_pins_o.strobe_pair[l];
			end
		end
	end

	// idle pins at time zero; reset pin low from power on
	initial begin
		cmd_pins = '1;
		cmd_pins.reset_n = 1'b0;
		cmd_pins.cke = 1'b0;
		drv = '0;
		drv.strobe_pair = {LANES{2'h1}};
	end

	// counted waits, cke held low until the end, no mode writes
	// reset pin pulled low here too, so the same task serves a mid-run reset cycle
	task automatic power_up(input int hold, input int wait_cyc, input logic term);
		cmd_pins.cs_n = 1'b1;
		cmd_pins.cke = 1'b0;
		cmd_pins.reset_n = 1'b0;
		cmd_pins.termination_control = term;
		repeat (hold) @(negedge clk);
		cmd_pins.reset_n = 1'b1;
		repeat (wait_cyc) @(negedge clk);
		cmd_pins.cke = 1'b1;
	endtask

	// one command cycle, then one deselect cycle with the lines moved off
	// the idle cycle keeps a following call from rewriting the lines in the same step
	task automatic issue(input logic [2:0] op, input logic [2:0] ba, input logic [12:0] a);
		{cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} = op;
		cmd_pins.bank_select = ba;
		cmd_pins.row_col_lines = a;
		cmd_pins.cs_n = 1'b0;
		@(negedge clk);
		cmd_pins.cs_n = 1'b1;
		cmd_pins.row_col_lines = ~a;
		@(negedge clk);
	endtask

	// byte settles, pair toggles mid-window; byte released after the last
	// beat only, so back-to-back beats never rewrite the lane in one step
	task automatic wr_beat(input logic [15:0] d, input logic last);
		drv.byte_lane = d;
		repeat (2) @(negedge clk);
		for (int l = 0; l < LANES; l++) drv.strobe_pair[l] = ~drv.strobe_pair[l];
		repeat (2) @(negedge clk);
		if (last)
			drv.byte_lane = ~d;
	endtask
endmodule

// [verification/sdb_core_checker.sv]
// assertions on the ports of the burst access core
// assumes straps stay still through a read burst
module sdb_core_checker #(
	parameter int INIT_WAIT = 8
) (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic                       otf_chop_en,
	input wire logic                       fixed_chop,
	input wire sdb_pkg::sdb_cmd_pins_type  cmd_pins,
	input wire sdb_pkg::sdb_data_pins_type data_pins_o,
	input wire logic [1:0]                 data_oe,
	input wire logic [1:0]                 strobe_oe,
	input wire logic                       init_done,
	input wire logic                       termination_on
);
	timeunit 1ns;
	timeprecision 100ps;
	import sdb_pkg::*;
	logic [7:0] up_q;
	logic       rd_pin;

	// read command on the raw pins
	assign rd_pin = !cmd_pins.cs_n && cmd_pins.cke && {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} == CMD_RD;

	// cycles since the reset pin went high, saturating so it never wraps
	always_ff @(posedge clk) begin
		if (rst || !cmd_pins.reset_n) up_q <= 8'h00;
		else if (up_q != 8'hFF) up_q <= up_q + 8'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_lane_enables: assert property (data_oe == strobe_oe)
		else $error("data and strobe enables differ");
	chk_pair_diff: assert property (data_pins_o.strobe_pair[0][1] != data_pins_o.strobe_pair[0][0] && data_pins_o.strobe_pair[1][1] != data_pins_o.strobe_pair[1][0])
		else $error("strobe pair not complementary");
	chk_edge_beat: assert property (data_oe[0] |-> data_pins_o.strobe_pair[0][1] != $past(data_pins_o.strobe_pair[0][1]))
		else $error("read beat without strobe edge");
	chk_quiet_init: assert property (!init_done |-> data_oe == 2'h0)
		else $error("drive before init done");
	chk_init_time: assert property ($rose(init_done) |-> up_q inside {[INIT_WAIT+3:INIT_WAIT+5]})
		else $error("init done at wrong time");
	chk_reset_drop: assert property (!cmd_pins.reset_n [*3] |=> !init_done)
		else $error("init done kept in reset");
	chk_term_ready: assert property (termination_on |-> init_done)
		else $error("termination on before init done");
	chk_rd_latency: assert property ($rose(data_oe[0]) |-> $past(rd_pin, 4) || $past(rd_pin, 5) || $past(rd_pin, 6))
		else $error("read beats without read command");
	chk_chop_len: assert property ($rose(data_oe[0]) && !otf_chop_en && fixed_chop |-> data_oe[0] [*4] ##1 !data_oe[0])
		else $error("fixed chop burst not four beats");
	chk_full_len: assert property ($rose(data_oe[0]) && !otf_chop_en && !fixed_chop |-> data_oe[0] [*8] ##1 !data_oe[0])
		else $error("fixed full burst not eight beats");

	cov_init: cover property ($rose(init_done));
	cov_read: cover property ($rose(data_oe[0]));
	cov_both: cover property (data_oe == 2'h3);
endmodule

bind sdb_core sdb_core_checker #(.INIT_WAIT(INIT_WAIT)) u_chk (.clk(clk), .rst(rst), .otf_chop_en(otf_chop_en),
	.fixed_chop(fixed_chop), .cmd_pins(cmd_pins), .data_pins_o(data_pins_o), .data_oe(data_oe),
	.strobe_oe(strobe_oe), .init_done(init_done), .termination_on(termination_on));

// [verification/tb_sdram_powerup_and_burst_access.sv]
// self-checking bench: power-up, then random full write bursts and read bursts in every mode
// assumes the controller model drives all pins; init count shortened to 8
module tb_sdram_powerup_and_burst_access;
	timeunit 1ns;
	timeprecision 100ps;
	import sdb_pkg::*;
	localparam int IW = 8;
	logic clk = 1'b0;
	logic rst, otf, fixed, ilv, init_done, termination_on;
	logic [1:0] data_oe, strobe_oe;
	sdb_cmd_pins_type cmd_pins;
	sdb_data_pins_type data_pins_i, data_pins_o;
	logic [15:0] mem [SLOTS][BEATS];
	logic [31:0] seed = 32'hDB3A;
	int err_count = 0;
	int n_checks = 0;

	sdb_core #(.INIT_WAIT(IW)) uut (.clk(clk), .rst(rst), .otf_chop_en(otf), .fixed_chop(fixed),
		.burst_interleave(ilv), .cmd_pins(cmd_pins), .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
		.data_oe(data_oe), .strobe_oe(strobe_oe), .init_done(init_done), .termination_on(termination_on));
	sdb_ctrl_model u_ctrl (.clk(clk), .cmd_pins(cmd_pins), .data_pins_i(data_pins_i),
		.data_pins_o(data_pins_o), .data_oe(data_oe));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// beat position from start column and burst type
	function automatic int pos(input logic [2:0] c, input int i, input logic il);
		logic [2:0] k;
		k = i[2:0];
		if (il) return int'(c ^ k);
		return int'({c[2] ^ k[2], c[1:0] + k[1:0]});
	endfunction

	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t read beat %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			err_count++;
			$display("ERROR %0t count %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// full write burst; beats land in burst order from the start column
	task automatic wr(input logic [3:0] slot, input logic [2:0] c);
		logic [15:0] d;
		otf = 1'b1;
		u_ctrl.issue(CMD_WR, slot[3:1], {10'h200, c});
		repeat (2) @(negedge clk);
		for (int i = 0; i < BEATS; i++) begin
			d = 16'(rnd());
			u_ctrl.wr_beat(d, i == BEATS - 1);
			mem[slot][pos(c, i, ilv)] = d;
		end
	endtask

	// reset pin cycle: init must drop, then finish in bounded time; termination follows its pin
	task automatic boot(input logic term);
		u_ctrl.power_up(4, IW, term);
		chk_cnt(int'(init_done === 1'b0), 1);
		for (int t = 0; t < 100 && init_done !== 1'b1; t++) @(negedge clk);
		chk_cnt(int'(init_done === 1'b1), 1);
		if (init_done !== 1'b1) results();
		@(negedge clk);
		chk_cnt(int'(termination_on === term), 1);
	endtask

	// read burst sampled at falling edges, bounded window
	task automatic rd(input logic [3:0] slot, input logic [2:0] c, input logic ap, input logic a12, input int exp_n);
		int n;
		n = 0;
		u_ctrl.issue(CMD_RD, slot[3:1], {a12, 1'b0, ap, 7'h00, c});
		for (int t = 0; t < 20; t++) begin
			@(negedge clk);
			if (data_oe === 2'h3) begin
				if (n < BEATS) chk_data(data_pins_o.byte_lane, mem[slot][pos(c, n, ilv)]);
				n++;
			end
		end
		chk_cnt(n, exp_n);
	endtask

	// main sequence
	initial begin
		logic [31:0] r;
		logic [3:0] slot;
		rst = 1'b1;
		otf = 1'b0;
		fixed = 1'b0;
		ilv = 1'b0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		boot(1'b0);
		rd(4'h0, 3'h0, 1'b0, 1'b1, 0);
		for (int it = 0; it < 8; it++) begin
			r = rnd();
			slot = r[3:0];
			ilv = r[8];
			u_ctrl.issue(CMD_ACT, slot[3:1], 13'(slot[0]));
			wr(slot, r[11:9]);
			otf = it[0];
			fixed = it[1];
			rd(slot, r[6:4], r[7] | (it == 3), it[2], otf ? (it[2] ? 8 : 4) : (fixed ? 4 : 8));
			if (r[7] | (it == 3)) rd(slot, r[6:4], 1'b0, 1'b1, 0);
		end
		u_ctrl.issue(CMD_ACT, slot[3:1], 13'(slot[0]));
		u_ctrl.issue(CMD_PRE, 3'h0, 13'h0400);
		rd(slot, 3'h0, 1'b0, 1'b1, 0);
		// mid-run reset pin cycle: an open bank must not survive it
		u_ctrl.issue(CMD_ACT, slot[3:1], 13'(slot[0]));
		boot(1'b1);
		rd(slot, 3'h0, 1'b0, 1'b1, 0);
		u_ctrl.issue(CMD_ACT, slot[3:1], 13'(slot[0]));
		wr(slot, 3'h0);
		rd(slot, 3'h0, 1'b0, 1'b1, 8);
		results();
	end
endmodule
